// ---- logic/codec_serial_mode_control.sv ----
// Serial frame interpreter and configuration registers of a codec.
// Assumes the host serial port clocks data on rising serial_clock edges.
`timescale 1ns/1ps
module codec_serial_mode_control #(
   parameter int SCLK_HALF = 4
) (
   input  wire logic                                 sys_clk,
   input  wire logic                                 resetn,
   input  wire logic                                 port_enable_pin,
   input  wire logic                                 serial_data_in,
   input  wire logic                                 input_frame_sync,
   output logic                                      serial_clock,
   output logic                                      serial_data_out,
   output logic                                      output_frame_sync,
   input  wire logic [codec_ctl_pkg::FRAME_BITS-1:0] adc_sample,
   output logic      [codec_ctl_pkg::FRAME_BITS-1:0] dac_word,
   output logic                                      dac_valid,
   input  wire logic                                 dac_ready,
   output logic                                      operating_mode_bit,
   output logic                                      mixed_mode_enable,
   output logic      [2:0]                           device_count_field,
   output logic      [1:0]                           rate_select_field,
   output logic                                      device_power_on,
   output logic                                      adc_power_on,
   output logic                                      dac_power_on,
   output logic                                      reference_power_on,
   output logic                                      reference_output_use,
   output logic      [2:0]                           input_gain_select,
   output logic                                      modulator_hold_reset,
   output logic      [2:0]                           output_gain_select,
   output logic                                      output_mute,
   output logic      [4:0]                           dac_advance_setting,
   output logic                                      interpolator_bypass,
   output logic                                      single_ended_select,
   output logic                                      input_polarity_flip,
   output logic                                      analog_loopback
);
   import codec_ctl_pkg::*;

   localparam int HALF_W = $clog2(SCLK_HALF + 1);
   localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(SCLK_HALF - 1);

   // Pin synchronisers: index 0 enable, 1 data, 2 frame sync
   logic [2:0]             sync1_q;
   logic [2:0]             sync2_q;
   logic                   enable_s;
   logic                   sdi_s;
   logic                   ifs_s;

   logic [HALF_W-1:0]      half_q;
   logic                   sclk_q;
   logic                   rise_tick;
   logic                   fall_tick;

   logic [11:0]            fs_cnt_q;
   logic [11:0]            fs_last;
   logic                   start_q;
   logic [FRAME_BITS-1:0]  tx_shift_q;
   logic [4:0]             tx_cnt_q;
   logic                   ofs_q;
   logic                   sdo_q;

   logic [FRAME_BITS-1:0]  rx_shift_q;
   logic [4:0]             rx_cnt_q;
   logic                   rx_done_q;

   logic [FRAME_BITS-1:0]  frame_q;
   logic                   pend_q;
   logic [FRAME_BITS-1:0]  fwd_word_q;
   logic                   fwd_valid_q;
   logic [7:0]             regs_q [REG_COUNT];
   logic                   rate_set_q;
   logic [2:0]             dcnt_q;

   logic                   config_open;
   logic                   is_control;
   logic                   is_data;
   logic                   data_mine;
   logic                   go;
   logic [2:0]             addr;
   logic [2:0]             sel;
   logic [7:0]             read_val;
   logic                   do_write;
   logic                   do_read;
   logic                   do_forward;
   logic                   do_swreset;
   logic [FRAME_BITS-1:0]  dac_in;
   logic                   dac_push;
   logic                   dac_in_ready;
   logic                   tx_load;

   // Two-flop synchronisers
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end
      else
      begin
         sync1_q <= {input_frame_sync, serial_data_in, port_enable_pin};
         sync2_q <= sync1_q;
      end
   end
   assign enable_s = sync2_q[0];
   assign sdi_s    = sync2_q[1];
   assign ifs_s    = sync2_q[2];

   // Serial clock divider
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         half_q <= '0;
         sclk_q <= 1'b0;
      end
      else if (half_q == HALF_LAST)
      begin
         half_q <= '0;
         sclk_q <= ~sclk_q;
      end
      else
         half_q <= half_q + HALF_W'(1);
   end
   assign rise_tick    = (half_q == HALF_LAST) && !sclk_q;
   assign fall_tick    = (half_q == HALF_LAST) && sclk_q;
   assign serial_clock = sclk_q;

   // Sample event timer
   assign fs_last = rate_set_q ? 12'({FS_DIV_BASE, 3'h7} >> regs_q[REG_B][B_RATE_HI:B_RATE_LO])
                               : FS_DIV_SLOW;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fs_cnt_q <= 12'h000;
         start_q  <= 1'b0;
      end
      else
      begin
         if (fs_cnt_q >= fs_last)
            fs_cnt_q <= 12'h000;
         else
            fs_cnt_q <= fs_cnt_q + 12'h001;
         if (fs_cnt_q >= fs_last && enable_s)
            start_q <= 1'b1;
         else if (tx_load)
            start_q <= 1'b0;
      end
   end

   // Transmitter: one frame sync bit, then sixteen data bits
   assign tx_load = rise_tick && start_q && (tx_cnt_q == 5'h00);
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_shift_q <= '0;
         tx_cnt_q   <= 5'h00;
         ofs_q      <= 1'b0;
         sdo_q      <= 1'b0;
      end
      else if (rise_tick)
      begin
         ofs_q <= 1'b0;
         if (tx_cnt_q != 5'h00)
         begin
            sdo_q      <= tx_shift_q[FRAME_BITS-1];
            tx_shift_q <= tx_shift_q << 1;
            tx_cnt_q   <= tx_cnt_q - 5'h01;
         end
         else if (start_q)
         begin
            ofs_q    <= 1'b1;
            tx_cnt_q <= FRAME_COUNT;
            if (fwd_valid_q)
               tx_shift_q <= fwd_word_q;
            else if (mixed_mode_enable && operating_mode_bit)
               tx_shift_q <= {1'b0, adc_sample[FRAME_BITS-2:0]};
            else
               tx_shift_q <= adc_sample;
         end
      end
   end
   assign output_frame_sync = ofs_q;
   assign serial_data_out   = sdo_q;

   // Receiver: frame sync bit, then sixteen bits MSB first, sampled on falling serial clock
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_shift_q <= '0;
         rx_cnt_q   <= 5'h00;
         rx_done_q  <= 1'b0;
      end
      else
      begin
         rx_done_q <= 1'b0;
         if (fall_tick)
         begin
            if (rx_cnt_q != 5'h00)
            begin
               rx_shift_q <= {rx_shift_q[FRAME_BITS-2:0], sdi_s};
               rx_cnt_q   <= rx_cnt_q - 5'h01;
               rx_done_q  <= (rx_cnt_q == 5'h01);
            end
            else if (ifs_s)
               rx_cnt_q <= FRAME_COUNT;
         end
      end
   end

   // Frame decode
   assign config_open = !operating_mode_bit || mixed_mode_enable;
   assign is_control  = frame_q[CW_FLAG_BIT] && config_open;
   assign is_data     = operating_mode_bit && !(mixed_mode_enable && frame_q[CW_FLAG_BIT]);
   assign data_mine   = is_data && (dcnt_q == device_count_field);
   assign addr        = frame_q[CW_ADDR_HI:CW_ADDR_LO];
   assign sel         = frame_q[CW_REG_HI:CW_REG_LO];
   assign read_val    = (sel <= REG_F) ? regs_q[sel] : REG_RESET;
   assign go          = pend_q && !(data_mine && !dac_in_ready);
   assign do_forward  = go && is_control && (addr != ADDR_SELF);
   assign do_write    = go && is_control && (addr == ADDR_SELF) && !frame_q[CW_RW_BIT];
   assign do_read     = go && is_control && (addr == ADDR_SELF) && frame_q[CW_RW_BIT];
   assign do_swreset  = do_write && (sel == REG_A) && frame_q[A_SWRESET_BIT];
   assign dac_push    = go && data_mine;
   assign dac_in      = mixed_mode_enable ? {frame_q[FRAME_BITS-2:0], 1'b0} : frame_q;

   // Received frame holding stage
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         frame_q <= '0;
         pend_q  <= 1'b0;
      end
      else if (rx_done_q)
      begin
         frame_q <= rx_shift_q;
         pend_q  <= 1'b1;
      end
      else if (go)
         pend_q <= 1'b0;
   end

   // Forwarded or read-back word for the next output frame
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_word_q  <= '0;
         fwd_valid_q <= 1'b0;
      end
      else if (do_forward)
      begin
         fwd_word_q  <= {frame_q[CW_FLAG_BIT:CW_RW_BIT], addr - ADDR_STEP, frame_q[CW_REG_HI:0]};
         fwd_valid_q <= 1'b1;
      end
      else if (do_read)
      begin
         fwd_word_q  <= {frame_q[CW_FLAG_BIT:CW_REG_LO], read_val};
         fwd_valid_q <= 1'b1;
      end
      else if (tx_load)
         fwd_valid_q <= 1'b0;
   end

   // Control registers; software reset returns all to default
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            regs_q[i] <= REG_RESET;
         rate_set_q <= 1'b0;
      end
      else if (do_swreset)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            regs_q[i] <= REG_RESET;
         rate_set_q <= 1'b0;
      end
      else if (do_write && sel <= REG_F)
      begin
         regs_q[sel] <= frame_q[CW_DATA_HI:0];
         if (sel == REG_B)
            rate_set_q <= 1'b1;
      end
   end

   // Input frame counter for cascade DAC updates
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         dcnt_q <= 3'h0;
      else if (do_swreset || !operating_mode_bit)
         dcnt_q <= 3'h0;
      else if (go && is_data)
      begin
         if (dcnt_q == device_count_field)
            dcnt_q <= 3'h0;
         else
            dcnt_q <= dcnt_q + 3'h1;
      end
   end

   two_entry_buffer #(
      .WIDTH     (FRAME_BITS)
   ) dac_buffer (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (dac_push),
      .in_ready  (dac_in_ready),
      .in_data   (dac_in),
      .out_valid (dac_valid),
      .out_ready (dac_ready),
      .out_data  (dac_word)
   );

   // Configuration outputs
   assign operating_mode_bit   = regs_q[REG_A][A_OPMODE_BIT];
   assign mixed_mode_enable    = regs_q[REG_A][A_MIXED_BIT];
   assign device_count_field   = regs_q[REG_A][A_DC_HI:A_DC_LO];
   assign rate_select_field    = regs_q[REG_B][B_RATE_HI:B_RATE_LO];
   assign device_power_on      = regs_q[REG_C][C_DEVICE_BIT];
   assign adc_power_on         = regs_q[REG_C][C_ADC_BIT];
   assign dac_power_on         = regs_q[REG_C][C_DAC_BIT];
   assign reference_power_on   = regs_q[REG_C][C_REF_BIT];
   assign reference_output_use = regs_q[REG_C][C_REFOUT_BIT];
   assign input_gain_select    = regs_q[REG_D][D_IGAIN_HI:D_IGAIN_LO];
   assign modulator_hold_reset = regs_q[REG_D][D_MODRST_BIT];
   assign output_gain_select   = regs_q[REG_D][D_OGAIN_HI:D_OGAIN_LO];
   assign output_mute          = regs_q[REG_D][D_MUTE_BIT];
   assign dac_advance_setting  = regs_q[REG_E][E_ADV_HI:E_ADV_LO];
   assign interpolator_bypass  = regs_q[REG_E][E_BYPASS_BIT];
   assign single_ended_select  = regs_q[REG_F][F_SINGLE_BIT];
   assign input_polarity_flip  = regs_q[REG_F][F_INVERT_BIT];
   assign analog_loopback      = regs_q[REG_F][F_LOOP_BIT];

endmodule // codec_serial_mode_control

// ---- logic/codec_ctl_pkg.sv ----
// Constants for the codec serial frame interpreter and its control registers.
// Assumes one system clock that also serves as the converter master clock.
package codec_ctl_pkg;

   // Frame layout
   localparam int          FRAME_BITS    = 16;
   localparam int          CW_FLAG_BIT   = 15;
   localparam int          CW_RW_BIT     = 14;
   localparam int          CW_ADDR_HI    = 13;
   localparam int          CW_ADDR_LO    = 11;
   localparam int          CW_REG_HI     = 10;
   localparam int          CW_REG_LO     = 8;
   localparam int          CW_DATA_HI    = 7;
   localparam logic [4:0]  FRAME_COUNT   = 5'h10;
   localparam logic [2:0]  ADDR_SELF     = 3'h0;
   localparam logic [2:0]  ADDR_STEP     = 3'h1;

   // Register indices and reset value
   localparam int          REG_COUNT     = 6;
   localparam logic [2:0]  REG_A         = 3'h0;
   localparam logic [2:0]  REG_B         = 3'h1;
   localparam logic [2:0]  REG_C         = 3'h2;
   localparam logic [2:0]  REG_D         = 3'h3;
   localparam logic [2:0]  REG_E         = 3'h4;
   localparam logic [2:0]  REG_F         = 3'h5;
   localparam logic [7:0]  REG_RESET     = 8'h00;

   // control_reg_a fields
   localparam int          A_OPMODE_BIT  = 0;
   localparam int          A_MIXED_BIT   = 1;
   localparam int          A_DC_LO       = 4;
   localparam int          A_DC_HI       = 6;
   localparam int          A_SWRESET_BIT = 7;
   // control_reg_b rate_select_field
   localparam int          B_RATE_LO     = 0;
   localparam int          B_RATE_HI     = 1;
   // power_control fields
   localparam int          C_DEVICE_BIT  = 0;
   localparam int          C_ADC_BIT     = 3;
   localparam int          C_DAC_BIT     = 4;
   localparam int          C_REF_BIT     = 5;
   localparam int          C_REFOUT_BIT  = 6;
   // gain_mute_control fields
   localparam int          D_IGAIN_LO    = 0;
   localparam int          D_IGAIN_HI    = 2;
   localparam int          D_MODRST_BIT  = 3;
   localparam int          D_OGAIN_LO    = 4;
   localparam int          D_OGAIN_HI    = 6;
   localparam int          D_MUTE_BIT    = 7;
   // dac_advance_bypass fields
   localparam int          E_ADV_LO      = 0;
   localparam int          E_ADV_HI      = 4;
   localparam int          E_BYPASS_BIT  = 5;
   // input_loopback_config fields
   localparam int          F_SINGLE_BIT  = 5;
   localparam int          F_INVERT_BIT  = 6;
   localparam int          F_LOOP_BIT    = 7;

   // Output frame sync dividers, in master clock cycles
   localparam logic [11:0] FS_DIV_SLOW   = 12'h7FF;  // 2048 - 1
   localparam logic [11:0] FS_DIV_BASE   = 12'h0FF;  // 256 - 1, scaled by rate field

endpackage

// ---- logic/two_entry_buffer.sv ----
// Two-entry valid/ready buffer for DAC words.
// Assumes both sides run on sys_clk; out_ready may stall at any time.
`timescale 1ns/1ps
module two_entry_buffer #(
   parameter int WIDTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic             wr_ptr_q;
   logic             rd_ptr_q;
   logic [1:0]       count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= ~wr_ptr_q;
         if (pop)
            rd_ptr_q <= ~rd_ptr_q;
         if (push && !pop)
            count_q <= count_q + 2'h1;
         else if (pop && !push)
            count_q <= count_q - 2'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem_q[wr_ptr_q] <= in_data;
   end
endmodule // two_entry_buffer

// ---- tb/codec_ctl_asserts.sv ----
// Checker for the codec serial frame interpreter, bound to its top module.
// Assumes one sys_clk domain and a serial clock of 2*SCLK_HALF cycles.
`timescale 1ns/1ps
module codec_ctl_asserts #(
   parameter int SCLK_HALF = 4
) (
   input wire logic                                 sys_clk,
   input wire logic                                 resetn,
   input wire logic                                 port_enable_pin,
   input wire logic                                 serial_clock,
   input wire logic                                 serial_data_out,
   input wire logic                                 output_frame_sync,
   input wire logic [codec_ctl_pkg::FRAME_BITS-1:0] dac_word,
   input wire logic                                 dac_valid,
   input wire logic                                 dac_ready,
   input wire logic                                 operating_mode_bit,
   input wire logic                                 mixed_mode_enable,
   input wire logic [1:0]                           rate_select_field,
   input wire logic                                 device_power_on,
   input wire logic [2:0]                           output_gain_select,
   input wire logic                                 output_mute,
   input wire logic [4:0]                           dac_advance_setting,
   input wire logic                                 analog_loopback
);
   import codec_ctl_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [7:0]  hi_q;
   logic [11:0] gap_q;
   logic        armed_q;
   logic        chg_q;

   // Length of each output frame sync pulse
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         hi_q <= 8'h00;
      else
         hi_q <= output_frame_sync ? hi_q + 8'h01 : 8'h00;
   end

   // Spacing of output frame syncs
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gap_q   <= 12'h000;
         armed_q <= 1'h0;
         chg_q   <= 1'h0;
      end
      else if ($rose(output_frame_sync))
      begin
         gap_q   <= 12'h000;
         armed_q <= 1'h1;
         chg_q   <= 1'h0;
      end
      else
      begin
         gap_q <= gap_q + 12'h001;
         chg_q <= chg_q || $changed(rate_select_field);
      end
   end

   a_frame_rate: assert property (
      $rose(output_frame_sync) && armed_q && !chg_q && !$changed(rate_select_field)
      |-> int'(gap_q) == (256 << (3 - int'(rate_select_field))) - 1)
      else $error("output frame sync spacing wrong");
   a_sync_width: assert property ($fell(output_frame_sync) |-> int'(hi_q) == 2 * SCLK_HALF)
      else $error("output frame sync width wrong");
   a_sync_enable: assert property ($rose(output_frame_sync) |-> $past(port_enable_pin, 2))
      else $error("frame sync without port enable");
   a_data_lock: assert property (operating_mode_bit && !mixed_mode_enable |=> operating_mode_bit &&
      $stable({device_power_on, output_gain_select, output_mute, dac_advance_setting, analog_loopback}))
      else $error("configuration changed in data mode");
   a_dac_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_word))
      else $error("stalled DAC word lost");
   a_mixed_lsb: assert property (dac_valid && operating_mode_bit && mixed_mode_enable |-> !dac_word[0])
      else $error("mixed DAC word LSB not zero");
   a_prog_no_dac: assert property (!operating_mode_bit && !dac_valid |=> !dac_valid)
      else $error("DAC word loaded in program mode");
   a_sdo_on_rise: assert property ($changed(serial_data_out) |-> $rose(serial_clock))
      else $error("serial data changed off the rising clock");
   a_reset_clear: assert property ($rose(resetn) |-> !operating_mode_bit && !dac_valid &&
      !device_power_on && output_gain_select == 3'h0 && rate_select_field == 2'h0)
      else $error("outputs not cleared by reset");

   c_mixed_pop: cover property (dac_valid && dac_ready && mixed_mode_enable);
   c_dac_stall: cover property (dac_valid && !dac_ready ##1 dac_valid && !dac_ready);
   c_fast_rate: cover property ($rose(output_frame_sync) && rate_select_field == 2'h3);
endmodule // codec_ctl_asserts

bind codec_serial_mode_control codec_ctl_asserts #(.SCLK_HALF(SCLK_HALF)) u_chk (
   .sys_clk, .resetn, .port_enable_pin, .serial_clock, .serial_data_out, .output_frame_sync,
   .dac_word, .dac_valid, .dac_ready, .operating_mode_bit, .mixed_mode_enable, .rate_select_field,
   .device_power_on, .output_gain_select, .output_mute, .dac_advance_setting, .analog_loopback);

// ---- tb/host_sport_model.sv ----
// Host serial port model: sends 16-bit frames, collects output frames.
// Assumes the device sources serial_clock and both frame syncs lead by one period.
`timescale 1ns/1ps
module host_sport_model (
   input  wire logic        serial_clock,
   input  wire logic        serial_data_out,
   input  wire logic        output_frame_sync,
   output logic             serial_data_in,
   output logic             input_frame_sync,
   output logic      [15:0] rx_word,
   output int               rx_cnt
);
   int bits;

   initial
   begin
      serial_data_in = 1'h0;
      input_frame_sync = 1'h0;
      rx_word = 16'h0000;
      rx_cnt = 0;
      bits = 0;
   end

   // One frame, MSB first, changed on rising serial clock
   task automatic send(input logic [15:0] w);
      @(posedge serial_clock);
      input_frame_sync <= 1'h1;
      for (int i = 15; i >= 0; i--)
      begin
         @(posedge serial_clock);
         input_frame_sync <= 1'h0;
         serial_data_in   <= w[i];
      end
      @(posedge serial_clock);
      serial_data_in <= ~w[0];
   endtask

   // Capture output words on falling serial clock
   always @(negedge serial_clock)
   begin
      if (bits > 0)
      begin
         rx_word = {rx_word[14:0], serial_data_out};
         bits = bits - 1;
         if (bits == 0)
            rx_cnt = rx_cnt + 1;
      end
      else if (output_frame_sync === 1'h1)
         bits = 16;
   end
endmodule // host_sport_model

// ---- tb/tb_codec_serial_mode_control.sv ----
// Self-checking bench for the codec serial frame interpreter.
// Assumes the host model on the serial pins and the bench as DAC consumer.
`timescale 1ns/1ps
module tb_codec_serial_mode_control;
   import codec_ctl_pkg::*;
   logic        sys_clk, resetn, port_enable_pin, serial_data_in, input_frame_sync, serial_clock;
   logic        serial_data_out, output_frame_sync, dac_valid, dac_ready, operating_mode_bit;
   logic        mixed_mode_enable, device_power_on, adc_power_on, dac_power_on, reference_power_on;
   logic        reference_output_use, modulator_hold_reset, output_mute, interpolator_bypass;
   logic        single_ended_select, input_polarity_flip, analog_loopback;
   logic [15:0] adc_sample, dac_word, rx_word, d;
   logic [2:0]  device_count_field, input_gain_select, output_gain_select;
   logic [1:0]  rate_select_field;
   logic [4:0]  dac_advance_setting;
   logic [7:0]  shadow [2:5];
   logic [7:0]  mask [2:5] = '{8'h79, 8'hFF, 8'h3F, 8'hE0};
   logic [15:0] dq [$];
   logic [15:0] rxq [$];
   int          rxd [$];
   int          rx_cnt, error_cnt, samples_checked;

   codec_serial_mode_control #(.SCLK_HALF(4)) dut (
      .sys_clk, .resetn, .port_enable_pin, .serial_data_in, .input_frame_sync, .serial_clock,
      .serial_data_out, .output_frame_sync, .adc_sample, .dac_word, .dac_valid, .dac_ready,
      .operating_mode_bit, .mixed_mode_enable, .device_count_field, .rate_select_field,
      .device_power_on, .adc_power_on, .dac_power_on, .reference_power_on, .reference_output_use,
      .input_gain_select, .modulator_hold_reset, .output_gain_select, .output_mute,
      .dac_advance_setting, .interpolator_bypass, .single_ended_select, .input_polarity_flip,
      .analog_loopback);

   host_sport_model host (
      .serial_clock, .serial_data_out, .output_frame_sync, .serial_data_in, .input_frame_sync,
      .rx_word, .rx_cnt);

   initial
   begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [15:0] cw(input logic rd, input logic [2:0] a, input logic [2:0] r,
                                      input logic [7:0] v);
      return {1'h1, rd, a, r, v};
   endfunction

   function automatic logic [7:0] img(input int r);
      case (r)
         2: return {1'h0, reference_output_use, reference_power_on, dac_power_on, adc_power_on, 2'h0,
                    device_power_on};
         3: return {output_mute, output_gain_select, modulator_hold_reset, input_gain_select};
         4: return {2'h0, interpolator_bypass, dac_advance_setting};
         default: return {analog_loopback, input_polarity_flip, single_ended_select, 5'h00};
      endcase
   endfunction

   task automatic frame(input logic [15:0] w);
      host.send(w);
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic cmp_regs;
      for (int r = 2; r <= 5; r++)
         check(img(r), shadow[r]);
   endtask

   // Word expected within the next three output frames
   task automatic expect_rx(input logic [15:0] w);
      rxq.push_back(w);
      rxd.push_back(rx_cnt + 3);
      for (int i = 0; i < 2000 && rxq.size() > 0; i++)
         @(posedge sys_clk);
      check(16'(rxq.size()), 16'h0000);
   endtask

   task automatic drain;
      for (int i = 0; i < 800 && dq.size() > 0; i++)
      begin
         @(posedge sys_clk);
         dac_ready <= 1'($urandom);
      end
      @(posedge sys_clk);
      dac_ready <= 1'h1;
      check(16'(dq.size()), 16'h0000);
   endtask

   // Only queued words are compared; program mode output is undefined
   always @(rx_cnt)
   begin
      if (rxq.size() > 0 && (rx_word === rxq[0] || rx_cnt >= rxd[0]))
      begin
         check(rx_word, rxq.pop_front());
         void'(rxd.pop_front());
      end
   end

   always @(posedge sys_clk)
   begin
      if (resetn === 1'h1 && dac_valid === 1'h1 && dac_ready === 1'h1)
         check(dac_word, dq.size() > 0 ? dq.pop_front() : ~dac_word);
   end

   initial
   begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      end_sim;
   end

   initial
   begin
      resetn = 1'h0;
      port_enable_pin = 1'h0;
      adc_sample = 16'h0000;
      dac_ready = 1'h1;
      void'($urandom(32'h3D1E96AD));
      for (int r = 2; r <= 5; r++)
         shadow[r] = 8'h00;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'h1;
      @(posedge sys_clk);
      cmp_regs;
      adc_sample <= 16'h8000 | 16'($urandom);
      port_enable_pin <= 1'h1;
      frame(cw(1'h0, 3'h0, REG_B, 8'h03));
      check(rate_select_field, 2'h3);
      repeat (2)
      begin
         for (int r = 2; r <= 5; r++)
         begin
            shadow[r] = 8'($urandom) & mask[r];
            frame(cw(1'h0, 3'h0, 3'(r), shadow[r]));
         end
         cmp_regs;
      end
      frame(cw(1'h0, 3'h0, REG_C, 8'h41) & 16'h7FFF);
      frame(cw(1'h0, 3'h2, REG_C, 8'h01));
      cmp_regs;
      expect_rx(cw(1'h0, 3'h1, REG_C, 8'h01));
      frame(cw(1'h1, 3'h0, REG_D, 8'h00));
      expect_rx(cw(1'h1, 3'h0, REG_D, shadow[3]));
      frame(cw(1'h0, 3'h0, REG_A, 8'h03));
      check({mixed_mode_enable, operating_mode_bit}, 2'h3);
      expect_rx({1'h0, adc_sample[14:0]});
      shadow[3] = 8'($urandom);
      frame(cw(1'h0, 3'h0, REG_D, shadow[3]));
      cmp_regs;
      dac_ready <= 1'h0;
      repeat (3)
      begin
         d = 16'($urandom) & 16'h7FFF;
         dq.push_back({d[14:0], 1'h0});
         frame(d);
      end
      check(dac_valid, 1'h1);
      drain;
      frame(cw(1'h0, 3'h0, REG_A, 8'h10));
      check(device_count_field, 3'h1);
      frame(cw(1'h0, 3'h0, REG_A, 8'h11));
      check({mixed_mode_enable, operating_mode_bit}, 2'h1);
      for (int i = 0; i < 4; i++)
      begin
         d = 16'($urandom);
         if (i % 2 == 1)
            dq.push_back(d);
         frame(d);
      end
      drain;
      frame(cw(1'h0, 3'h0, REG_C, 8'h00));
      cmp_regs;
      end_sim;
   end
endmodule // tb_codec_serial_mode_control
